/* include/irq_unit_pkg.sv */
// constants, types and helpers for the latched event interrupt unit
package irq_unit_pkg;

  // --------------------------------------------------------------------
  // clocking and debounce timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000; // system clock rate
  localparam int OSC_HZ = 32_768; // internal oscillator rate
  localparam int TICK_DIV = CLK_HZ / OSC_HZ; // cycles per oscillator tick
  localparam int SCP_DB_US = 4000; // short-circuit least debounce, us
  localparam int BTN_DB_MS = 30; // button debounce, ms
  localparam int DB1_MS = 1; // programmable debounce step one, ms
  localparam int DB2_MS = 10; // programmable debounce step two, ms
  localparam int CW = 12; // debounce counter width
  localparam logic [CW-1:0] SCP_TICKS = CW'((SCP_DB_US * OSC_HZ + 999_999) / 1_000_000);
  localparam logic [CW-1:0] BTN_TICKS = CW'((BTN_DB_MS * OSC_HZ + 999) / 1000);
  localparam logic [CW-1:0] DB1_TICKS = CW'((DB1_MS * OSC_HZ + 999) / 1000);
  localparam logic [CW-1:0] DB2_TICKS = CW'((DB2_MS * OSC_HZ + 999) / 1000);
  localparam logic [CW-1:0] ONE_TICK = 12'h001; // shortest debounce

  // --------------------------------------------------------------------
  // register map and field positions
  // --------------------------------------------------------------------
  localparam logic [7:0] STATUS_OFF = 8'h00; // latched flags, write 1 clears
  localparam logic [7:0] MASK_OFF = 8'h04; // mask bits, 1 masks
  localparam logic [7:0] SENSE_OFF = 8'h08; // live levels, read only
  localparam logic [7:0] CFG_OFF = 8'h0c; // debounce and edge settings
  localparam int NFLAG = 15; // flags in status and mask
  localparam int F_SCP = 0;
  localparam int F_BTN1 = 1;
  localparam int F_BTN2 = 2;
  localparam int F_BRST = 3;
  localparam int F_SILENT = 4;
  localparam int F_TKRST = 5;
  localparam int F_OSC = 6;
  localparam int F_THERM = 7; // four bits up from here
  localparam int F_GP = 11; // four bits up from here
  localparam logic [NFLAG-1:0] MASK_RST = 15'h7fff; // all masked
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  // power state as driven by the power state machine
  typedef enum logic [3:0] {
    PS_COIN, PS_OFF, PS_COLD, PS_WDOG, PS_ON, PS_UOWAIT, PS_MEMHOLD, PS_USEROFF, PS_WARM
  } pwr_state_t;

  // configuration register layout
  typedef struct packed {
    logic [7:0] gp_edge; // 2 bits per input: 0 rise, 1 fall, 2 both, 3 none
    logic [1:0] gp_db; // gp debounce select
    logic [1:0] thermal_debounce_setting; // thermal debounce select
    logic [1:0] btn_two_ext; // button two fall debounce extension
    logic [1:0] btn_one_ext; // button one fall debounce extension
  } cfg_t;

  // external pins and comparator levels
  typedef struct packed {
    logic button_one_pin;
    logic button_two_pin;
    logic watchdog_input_pin;
    logic short_circuit; // any regulator short detected
    logic button_reset_req; // reset request via buttons
    logic timekeeper_reset; // real time domain reset seen
    logic osc_xtal; // crystal selected as 32 kHz source
    logic [3:0] die_temp; // above 110, 120, 125, 130 C
    logic [3:0] gp_input;
    logic idpin_grounded;
    logic idpin_floating;
    logic idpin_done;
    logic busvolt_done;
  } pins_t;

  // ticks for a two-bit debounce selection
  function automatic logic [CW-1:0] db_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: db_ticks = ONE_TICK;
      2'h1: db_ticks = DB1_TICKS;
      2'h2: db_ticks = DB2_TICKS;
      default: db_ticks = BTN_TICKS;
    endcase
  endfunction

endpackage

/* logic/irq_unit.sv */
// latched event interrupt unit with AXI4-Lite register slave
//
// Contract
// - short flag after 4 to 8 ms high
// - button one flag on debounced 30 ms fall
// - button one level reads debounced input
// - button two flag on debounced 30 ms fall
// - button two level reads debounced input
// - two-bit setting extends button fall debounce
// - button reset request rise sets flag
// - watchdog restart sets flag, no debounce
// - timekeeper reset sets flag, no debounce
// - oscillator change flags both edges, level
// - four thermal flags, both edges, programmable
// - gp inputs: edge, debounce, mask, level
// - id pin grounded and floating levels
// - id measurement done level
// - bus voltage detection done level
// - registers reachable only in three states
// - line low outside watchdog and on
// - watchdog input acts only in on
// - flags stay set until host clears
// - write one clears, new event wins
// - mask blocks line, unmask raises it
// - masks reset to masked
module irq_unit #(
  parameter int TICK_CYCLES = irq_unit_pkg::TICK_DIV
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pins and power state
  input wire irq_unit_pkg::pins_t pins,
  input wire irq_unit_pkg::pwr_state_t pwr_state,
  // outputs to host and power control
  output logic irq_line,
  output logic watchdog_drop
);

  // --------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------
  localparam int ND = 11; // debounced channels: scp, btn1, btn2, therm, gp
  irq_unit_pkg::pins_t meta_reg, sync_reg, prev_reg; // pin synchroniser
  logic [1:0] warm_cnt_reg; // edges since reset, saturates at three
  logic warm; // synchroniser primed, edge detectors trusted
  logic [15:0] tick_cnt_reg; // oscillator tick divider
  logic tick_reg; // one-cycle 32 kHz enable
  logic [ND-1:0] db_raw; // debounce inputs
  logic [ND-1:0] deb_reg, deb_d_reg; // debounced level and its delay
  logic [irq_unit_pkg::CW-1:0] cnt_reg [ND]; // debounce counters
  logic [irq_unit_pkg::CW-1:0] rise_lim [ND];
  logic [irq_unit_pkg::CW-1:0] fall_lim [ND];
  logic [ND-1:0] db_rise, db_fall;
  irq_unit_pkg::cfg_t cfg_reg; // configuration
  logic [irq_unit_pkg::NFLAG-1:0] status_reg, mask_reg; // flags and masks
  logic [irq_unit_pkg::NFLAG-1:0] set_vec, clr_vec, status_next;
  logic run_state, acc_ok; // power state qualifiers
  logic aw_full_reg, w_full_reg; // held write halves
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg, wmask_reg;
  logic wr_go, wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  // word address check
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == irq_unit_pkg::STATUS_OFF) || (a == irq_unit_pkg::MASK_OFF) ||
             (a == irq_unit_pkg::SENSE_OFF) || (a == irq_unit_pkg::CFG_OFF);
  endfunction

  // --------------------------------------------------------------------
  // pin synchroniser and tick divider
  // --------------------------------------------------------------------
  // two flops before any logic looks at a pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
      warm_cnt_reg <= 2'h0;
    end else begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      if (warm_cnt_reg != 2'h3) warm_cnt_reg <= warm_cnt_reg + 2'h1;
    end
  end

  // edges are held off until prev_reg holds a real pin sample, so a level
  // already high at reset is not taken for a fresh edge
  assign warm = (warm_cnt_reg == 2'h3);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // debounce
  // --------------------------------------------------------------------
  assign db_raw = {sync_reg.gp_input, sync_reg.die_temp, sync_reg.button_two_pin,
                   sync_reg.button_one_pin, sync_reg.short_circuit};

  // per-channel limits in ticks
  always_comb begin
    for (int i = 0; i < ND; i++) begin
      rise_lim[i] = irq_unit_pkg::db_ticks(cfg_reg.gp_db);
      fall_lim[i] = irq_unit_pkg::db_ticks(cfg_reg.gp_db);
      if (i >= 3 && i < 7) begin
        rise_lim[i] = irq_unit_pkg::db_ticks(cfg_reg.thermal_debounce_setting);
        fall_lim[i] = irq_unit_pkg::db_ticks(cfg_reg.thermal_debounce_setting);
      end
    end
    rise_lim[0] = irq_unit_pkg::SCP_TICKS;
    fall_lim[0] = irq_unit_pkg::ONE_TICK;
    rise_lim[1] = irq_unit_pkg::BTN_TICKS;
    fall_lim[1] = irq_unit_pkg::CW'(irq_unit_pkg::BTN_TICKS * ({2'h0, cfg_reg.btn_one_ext} + 4'h1));
    rise_lim[2] = irq_unit_pkg::BTN_TICKS;
    fall_lim[2] = irq_unit_pkg::CW'(irq_unit_pkg::BTN_TICKS * ({2'h0, cfg_reg.btn_two_ext} + 4'h1));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deb_reg <= '0;
      deb_d_reg <= '0;
      for (int i = 0; i < ND; i++) cnt_reg[i] <= '0;
    end else begin
      deb_d_reg <= deb_reg;
      for (int i = 0; i < ND; i++) begin
        if (db_raw[i] == deb_reg[i]) begin
          cnt_reg[i] <= '0;
        end else if (tick_reg) begin
          if (cnt_reg[i] + 1'b1 >= (db_raw[i] ? rise_lim[i] : fall_lim[i])) begin
            deb_reg[i] <= db_raw[i];
            cnt_reg[i] <= '0;
          end else begin
            cnt_reg[i] <= cnt_reg[i] + 1'b1;
          end
        end
      end
    end
  end

  assign db_rise = deb_reg & ~deb_d_reg;
  assign db_fall = ~deb_reg & deb_d_reg;

  // --------------------------------------------------------------------
  // event flags
  // --------------------------------------------------------------------
  assign run_state = (pwr_state == irq_unit_pkg::PS_WDOG) || (pwr_state == irq_unit_pkg::PS_ON);
  assign acc_ok = run_state || (pwr_state == irq_unit_pkg::PS_UOWAIT);

  // hardware set events
  always_comb begin
    set_vec = '0;
    set_vec[irq_unit_pkg::F_SCP] = db_rise[0];
    set_vec[irq_unit_pkg::F_BTN1] = db_fall[1];
    set_vec[irq_unit_pkg::F_BTN2] = db_fall[2];
    set_vec[irq_unit_pkg::F_BRST] = warm &
                                    sync_reg.button_reset_req & ~prev_reg.button_reset_req;
    set_vec[irq_unit_pkg::F_SILENT] = (pwr_state == irq_unit_pkg::PS_ON) &&
                                      !sync_reg.watchdog_input_pin && prev_reg.watchdog_input_pin;
    set_vec[irq_unit_pkg::F_TKRST] = warm &
                                     sync_reg.timekeeper_reset & ~prev_reg.timekeeper_reset;
    set_vec[irq_unit_pkg::F_OSC] = (sync_reg.osc_xtal ^ prev_reg.osc_xtal) & warm;
    set_vec[irq_unit_pkg::F_THERM +: 4] = db_rise[6:3] | db_fall[6:3];
    for (int g = 0; g < 4; g++) begin
      unique case (cfg_reg.gp_edge[2*g +: 2])
        2'h0: set_vec[irq_unit_pkg::F_GP + g] = db_rise[7 + g];
        2'h1: set_vec[irq_unit_pkg::F_GP + g] = db_fall[7 + g];
        2'h2: set_vec[irq_unit_pkg::F_GP + g] = db_rise[7 + g] | db_fall[7 + g];
        2'h3: set_vec[irq_unit_pkg::F_GP + g] = 1'b0;
      endcase
    end
  end

  assign clr_vec = (wr_go && wr_hit && waddr_reg == irq_unit_pkg::STATUS_OFF) ?
                   irq_unit_pkg::NFLAG'(wdata_reg & wmask_reg) : '0;
  assign status_next = (status_reg & ~clr_vec) | set_vec;

  // latched status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_drop <= 1'b0;
    end else begin
      watchdog_drop <= set_vec[irq_unit_pkg::F_SILENT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_line <= 1'b0;
    end else begin
      irq_line <= run_state && |(status_reg & ~mask_reg);
    end
  end

  // --------------------------------------------------------------------
  // axi4-lite write
  // --------------------------------------------------------------------
  assign wr_go = aw_full_reg && w_full_reg && !bvalid;
  assign wr_hit = acc_ok && mapped(waddr_reg);

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wmask_reg <= 32'h0000_0000;
      bvalid <= 1'b0;
      bresp <= irq_unit_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_full_reg <= 1'b1;
        awready <= 1'b0;
        waddr_reg <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_full_reg <= 1'b1;
        wready <= 1'b0;
        wdata_reg <= wdata;
        wmask_reg <= {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= !acc_ok ? irq_unit_pkg::RESP_SLVERR :
                 !mapped(waddr_reg) ? irq_unit_pkg::RESP_DECERR : irq_unit_pkg::RESP_OKAY;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= irq_unit_pkg::MASK_RST;
      cfg_reg <= irq_unit_pkg::CFG_RST;
    end else if (wr_go && wr_hit) begin
      if (waddr_reg == irq_unit_pkg::MASK_OFF) begin
        mask_reg <= (mask_reg & ~irq_unit_pkg::NFLAG'(wmask_reg)) |
                    irq_unit_pkg::NFLAG'(wdata_reg & wmask_reg);
      end
      if (waddr_reg == irq_unit_pkg::CFG_OFF) begin
        cfg_reg <= (cfg_reg & ~wmask_reg[15:0]) | (wdata_reg[15:0] & wmask_reg[15:0]);
      end
    end
  end

  // --------------------------------------------------------------------
  // axi4-lite read
  // --------------------------------------------------------------------
  assign rd_hit = acc_ok && mapped({araddr[7:2], 2'b00});

  // read word select
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case ({araddr[7:2], 2'b00})
      irq_unit_pkg::STATUS_OFF: rd_word = {17'h0, status_reg};
      irq_unit_pkg::MASK_OFF: rd_word = {17'h0, mask_reg};
      irq_unit_pkg::SENSE_OFF: rd_word = {17'h0, sync_reg.busvolt_done, sync_reg.idpin_done,
                                          sync_reg.idpin_floating, sync_reg.idpin_grounded,
                                          deb_reg[10:3], sync_reg.osc_xtal, deb_reg[2:1]};
      irq_unit_pkg::CFG_OFF: rd_word = {16'h0, cfg_reg};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // one read in flight, answered next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= irq_unit_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_hit ? rd_word : 32'h0000_0000;
      rresp <= !acc_ok ? irq_unit_pkg::RESP_SLVERR :
               !rd_hit ? irq_unit_pkg::RESP_DECERR : irq_unit_pkg::RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_flag_pending;
    run_state && |(status_reg & ~mask_reg);
  endsequence

  AST_LINE_LOW: assert property (!run_state |=> !irq_line)
    else $error("interrupt line high outside run states");
  AST_UNMASK_RAISES: assert property (s_flag_pending |=> irq_line)
    else $error("pending unmasked flag did not raise line");
  AST_MASK_RESET: assert property ($past(!aresetn) |-> mask_reg == irq_unit_pkg::MASK_RST)
    else $error("masks not all set after reset");
  AST_STICKY: assert property (1'b1 |=> ($past(status_reg) & ~$past(clr_vec) & ~status_reg) == '0)
    else $error("flag lost without a clear");
  AST_SET_WINS: assert property (set_vec != '0 |=> (status_reg & $past(set_vec)) == $past(set_vec))
    else $error("event lost during clear");
  AST_SCP_DB: assert property ($rose(deb_reg[0]) |-> $past(cnt_reg[0]) == irq_unit_pkg::SCP_TICKS - 1'b1)
    else $error("short flag debounce length wrong");
  AST_BTN_FALL: assert property ($fell(deb_reg[1]) |-> $past(cnt_reg[1]) == $past(fall_lim[1]) - 1'b1)
    else $error("button one fall debounce length wrong");
  AST_BTN1_FLAG: assert property ($fell(deb_reg[1]) |=> status_reg[irq_unit_pkg::F_BTN1])
    else $error("button one flag not set on fall");
  AST_WDI_ON: assert property (set_vec[irq_unit_pkg::F_SILENT] |-> pwr_state == irq_unit_pkg::PS_ON)
    else $error("watchdog input acted outside on");
  AST_REFUSE: assert property (wr_go && !acc_ok |=> bvalid && bresp == irq_unit_pkg::RESP_SLVERR)
    else $error("write outside access states not refused");
  AST_DB_RESTART: assert property (db_raw[0] == deb_reg[0] |=> cnt_reg[0] == '0)
    else $error("debounce counter not restarted");

endmodule // irq_unit

/* bench/host_model.sv */
// host processor model: axi4-lite master with bounded waits
module host_model (
  // clock
  input wire logic aclk,
  // write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  // a wait ran out
  output logic hang
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 1000; // edges before giving up

  // idle values at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, hang} = '0;
  end

  // ------------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------------
  // one write: address and data driven together, then waits for the response
  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h1;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < LIMIT) begin
      @(posedge aclk);
      n++;
      // release each channel once taken, scramble released data
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        n = LIMIT + 1;
      end
    end
    if (n == LIMIT) hang <= 1'b1;
  endtask

  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    d = 32'h0;
    r = 2'h1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < LIMIT) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        n = LIMIT + 1;
      end
    end
    if (n == LIMIT) hang <= 1'b1;
  endtask
endmodule // host_model

/* bench/tb_top.sv */
// self-checking bench for the event interrupt unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4; // shortened oscillator tick
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq_line, watchdog_drop, hang;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, nt, ng, ot, og, id;
  logic [1:0] bresp, rresp, rs;
  irq_unit_pkg::pins_t pins;
  irq_unit_pkg::pwr_state_t pwr_state, st;
  int fail_count, comparisons, drops;

  irq_unit #(.TICK_CYCLES(TK)) u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pins(pins), .pwr_state(pwr_state), .irq_line(irq_line),
    .watchdog_drop(watchdog_drop));
  host_model u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .hang(hang));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    u_host.read(a, rd, rs);
    check(rd, e);
    check({30'h0, rs}, {30'h0, er});
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    u_host.write(a, d, rs);
    check({30'h0, rs}, {30'h0, irq_unit_pkg::RESP_OKAY});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic summarize;
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // per-input edge modes set below: rise, fall, both, none
  function automatic logic [3:0] gp_exp(input logic [3:0] o, input logic [3:0] n);
    return {1'b0, o[2] ^ n[2], o[1] & ~n[1], ~o[0] & n[0]};
  endfunction
  function automatic logic [31:0] sense_exp(input logic [3:0] t, g, i);
    return {17'h0, i[0], i[1], i[2], i[3], g, t, 3'h0};
  endfunction

  // clock, hang cut-off and drop pulse count
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (watchdog_drop === 1'b1) drops++;
    if (hang === 1'b1) begin
      fail_count++;
      summarize();
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {fail_count, comparisons, drops} = '0;
    aresetn = 1'b0;
    pins = '0;
    pwr_state = irq_unit_pkg::PS_ON;
    {ot, og} = '0;
    rd = $urandom(27457);
    cyc(8);
    aresetn <= 1'b1;
    rreg(irq_unit_pkg::MASK_OFF, 32'h7fff, irq_unit_pkg::RESP_OKAY);
    rreg(8'h10, 32'h0, irq_unit_pkg::RESP_DECERR);
    wreg(irq_unit_pkg::CFG_OFF, 32'he404);
    pins.button_reset_req <= 1'b1;
    pins.timekeeper_reset <= 1'b1;
    cyc(8);
    {pins.button_reset_req, pins.timekeeper_reset} <= 2'b00;
    cyc(8);
    rreg(irq_unit_pkg::STATUS_OFF, 32'h28, irq_unit_pkg::RESP_OKAY);
    check({31'h0, irq_line}, 32'h0);
    wreg(irq_unit_pkg::MASK_OFF, 32'h7ff7);
    cyc(3);
    check({31'h0, irq_line}, 32'h1);
    wreg(irq_unit_pkg::STATUS_OFF, 32'h8);
    cyc(3);
    check({31'h0, irq_line}, 32'h0);
    rreg(irq_unit_pkg::STATUS_OFF, 32'h20, irq_unit_pkg::RESP_OKAY);
    pins.button_reset_req <= 1'b1;
    cyc(8);
    for (int s = 0; s < 9; s++) begin
      st = irq_unit_pkg::pwr_state_t'(s);
      pwr_state <= st;
      cyc(4);
      check({31'h0, irq_line}, {31'h0, st == irq_unit_pkg::PS_WDOG || st == irq_unit_pkg::PS_ON});
      if (st inside {irq_unit_pkg::PS_WDOG, irq_unit_pkg::PS_ON, irq_unit_pkg::PS_UOWAIT})
        rreg(irq_unit_pkg::MASK_OFF, 32'h7ff7, irq_unit_pkg::RESP_OKAY);
      else begin
        rreg(irq_unit_pkg::MASK_OFF, 32'h0, irq_unit_pkg::RESP_SLVERR);
        u_host.write(irq_unit_pkg::MASK_OFF, 32'h0, rs);
        check({30'h0, rs}, {30'h0, irq_unit_pkg::RESP_SLVERR});
      end
    end
    pins.button_reset_req <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      pwr_state <= s == 0 ? irq_unit_pkg::PS_ON : irq_unit_pkg::PS_WDOG;
      wreg(irq_unit_pkg::STATUS_OFF, 32'h7fff);
      pins.watchdog_input_pin <= 1'b1;
      cyc(8);
      pins.watchdog_input_pin <= 1'b0;
      cyc(8);
      rreg(irq_unit_pkg::STATUS_OFF, s == 0 ? 32'h10 : 32'h0, irq_unit_pkg::RESP_OKAY);
    end
    check(drops, 32'h1);
    pwr_state <= irq_unit_pkg::PS_ON;
    for (int s = 1; s >= 0; s--) begin
      wreg(irq_unit_pkg::STATUS_OFF, 32'h7fff);
      pins.osc_xtal <= s[0];
      cyc(8);
      rreg(irq_unit_pkg::STATUS_OFF, 32'h40, irq_unit_pkg::RESP_OKAY);
      rreg(irq_unit_pkg::SENSE_OFF, {29'h0, s[0], 2'h0}, irq_unit_pkg::RESP_OKAY);
    end
    wreg(irq_unit_pkg::STATUS_OFF, 32'h7fff);
    pins.short_circuit <= 1'b1;
    cyc(100 * TK);
    pins.short_circuit <= 1'b0;
    cyc(4 * TK);
    pins.short_circuit <= 1'b1;
    cyc(128 * TK);
    rreg(irq_unit_pkg::STATUS_OFF, 32'h0, irq_unit_pkg::RESP_OKAY);
    cyc(8 * TK);
    rreg(irq_unit_pkg::STATUS_OFF, 32'h1, irq_unit_pkg::RESP_OKAY);
    pins.short_circuit <= 1'b0;
    wreg(irq_unit_pkg::STATUS_OFF, 32'h7fff);
    {pins.button_one_pin, pins.button_two_pin} <= 2'b11;
    cyc(980 * TK);
    u_host.read(irq_unit_pkg::SENSE_OFF, rd, rs);
    check(rd & 32'h3, 32'h0);
    cyc(8 * TK);
    u_host.read(irq_unit_pkg::SENSE_OFF, rd, rs);
    check(rd & 32'h3, 32'h3);
    {pins.button_one_pin, pins.button_two_pin} <= 2'b00;
    for (int s = 1; s < 3; s++) begin
      cyc(988 * TK);
      u_host.read(irq_unit_pkg::STATUS_OFF, rd, rs);
      check(rd & 32'h6, s == 1 ? 32'h2 : 32'h6);
    end
    for (int i = 0; i < 8; i++) begin
      nt = 4'($urandom);
      ng = i == 0 ? 4'hf : 4'($urandom);
      id = 4'($urandom);
      wreg(irq_unit_pkg::STATUS_OFF, 32'h7fff);
      pins.die_temp <= nt;
      pins.gp_input <= ng;
      {pins.idpin_grounded, pins.idpin_floating, pins.idpin_done, pins.busvolt_done} <= id;
      cyc(6 * TK);
      rreg(irq_unit_pkg::STATUS_OFF, {17'h0, gp_exp(og, ng), ot ^ nt, 7'h0}, 2'h0);
      rreg(irq_unit_pkg::SENSE_OFF, sense_exp(nt, ng, id), 2'h0);
      ot = nt;
      og = ng;
    end
    // one millisecond debounce for thermal and gp inputs
    wreg(irq_unit_pkg::CFG_OFF, 32'he454);
    wreg(irq_unit_pkg::STATUS_OFF, 32'h7fff);
    pins.die_temp <= ~ot;
    pins.gp_input <= ~og;
    cyc(28 * TK);
    rreg(irq_unit_pkg::STATUS_OFF, 32'h0, irq_unit_pkg::RESP_OKAY);
    cyc(8 * TK);
    rreg(irq_unit_pkg::STATUS_OFF, {17'h0, gp_exp(og, ~og), 4'hf, 7'h0}, 2'h0);
    summarize();
  end
endmodule // tb_top
